// file: rtl/gcd_pkg.sv
// Package of constants for the clock distribution unit
package gcd_pkg;
  localparam int NUM_DIV      = 4;
  localparam int NUM_CHAN     = 8;
  localparam int NUM_SRC      = 8;
  localparam int DIV_W        = 8;
  localparam int ADDR_W       = 8;
  localparam int SRC_SEL_W    = 3;
  localparam int IDX_W        = 2;
  // Byte offsets
  localparam logic [7:0] OFS_CONTROL_A = 8'h00;
  localparam logic [7:0] OFS_DIV_BASE  = 8'h20;
  localparam logic [7:0] OFS_CHAN_BASE = 8'h80;
  // Control A fields
  localparam int CA_SOFT_RESET_POS = 0;
  // Divider unit control fields
  localparam int DU_SRC_POS    = 0;
  localparam int DU_ON_POS     = 8;
  localparam int DU_PAD_OE_POS = 11;
  localparam int DU_DIVIDE_SELECT_POS = 12;
  localparam int DU_FACTOR_POS = 16;
  // Channel control fields
  localparam int CH_IDX_POS  = 0;
  localparam int CH_EN_POS   = 6;
  localparam int CH_LOCK_POS = 7;
  // Reset values
  localparam logic [31:0] DU_RESET_VAL = 32'h0000_0000;
  localparam logic [31:0] CH_RESET_VAL = 32'h0000_0000;
  // Source slot in which divider unit 1 output appears for other units
  localparam logic [2:0] SRC_DIV1 = 3'h7;
endpackage : gcd_pkg

// file: rtl/gcd_div_if.sv
// Interface carrying one divider unit's settings and its clock out
`timescale 1ns/10ps
`default_nettype none
interface gcd_div_if;
  logic                          on;
  logic                          divide_select;
  logic [gcd_pkg::DIV_W-1:0]     factor;
  logic                          src_clk;
  logic                          clk_out;
  modport ctrl (output on, output divide_select, output factor, output src_clk, input clk_out);
  modport unit (input on, input divide_select, input factor, input src_clk, output clk_out);
endinterface : gcd_div_if
`default_nettype wire

// file: rtl/gcd_divider.sv
// One clock divider unit: pass-through or divide a sampled source
`timescale 1ns/10ps
`default_nettype none
module gcd_divider (
  input  wire logic  clock_in,
  input  wire logic  srst_in,
  gcd_div_if.unit    du
);
  logic                      src_d_r;
  logic [gcd_pkg::DIV_W-1:0] cnt_r;
  logic [gcd_pkg::DIV_W-1:0] cnt_nxt;
  logic                      div_r;
  logic                      div_nxt;
  logic                      out_r;
  logic                      src_rise;
  logic                      wrap;

  assign src_rise = du.src_clk & ~src_d_r;
  // Factor 0 and 1 both mean divide by two (toggle every source edge)
  assign wrap     = (cnt_r + 8'h01 >= du.factor);
  assign cnt_nxt  = wrap ? 8'h00 : cnt_r + 8'h01;
  assign div_nxt  = wrap ? ~div_r : div_r;

  always_ff @(posedge clock_in) begin
    if (srst_in || !du.on) begin
      src_d_r <= 1'b0;
      cnt_r   <= 8'h00;
      div_r   <= 1'b0;
      out_r   <= 1'b0;
    end else begin
      src_d_r <= du.src_clk;
      if (src_rise) begin
        cnt_r <= cnt_nxt;
        div_r <= div_nxt;
      end
      out_r <= du.divide_select ? div_r : du.src_clk;
    end
  end

  assign du.clk_out = out_r;
endmodule // gcd_divider
`default_nettype wire

// file: rtl/gcd_top.sv
// Clock distribution unit: divider units, channels and register port
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module gcd_top #(
  parameter int NUM_DIV  = gcd_pkg::NUM_DIV,
  parameter int NUM_CHAN = gcd_pkg::NUM_CHAN
) (
  input  wire logic                            clock_in,
  input  wire logic                            srst_in,
  input  wire logic [gcd_pkg::ADDR_W-1:0]      addr_in,
  input  wire logic [31:0]                     wdata_in,
  input  wire logic                            wr_in,
  input  wire logic                            rd_in,
  output logic      [31:0]                     rdata_out,
  input  wire logic [gcd_pkg::NUM_SRC-1:0]     src_clk_in,
  input  wire logic [NUM_DIV-1:0]              pad_in,
  output logic      [NUM_DIV-1:0]              pad_out,
  output logic      [NUM_DIV-1:0]              pad_oe_out,
  output logic                                 main_clock_feed_out,
  output logic      [NUM_CHAN-1:0]             peripheral_clock_out
);
  localparam logic [7:0] DIV_END  = gcd_pkg::OFS_DIV_BASE + 8'(4 * NUM_DIV);
  localparam logic [7:0] CHAN_END = gcd_pkg::OFS_CHAN_BASE + 8'(4 * NUM_CHAN);

  logic [31:0]         du_ctl_r [NUM_DIV];
  logic [31:0]         ch_ctl_r [NUM_CHAN];
  logic [31:0]         rdata_r;
  logic [NUM_DIV-1:0]  du_clk;
  logic [NUM_DIV-1:0]  du_keep;
  logic [NUM_CHAN-1:0] ch_keep;
  logic [NUM_CHAN-1:0] ch_clk_r;

  // Register decode
  logic       hit_ca;
  logic       hit_du;
  logic       hit_ch;
  logic [7:0] du_ofs;
  logic [7:0] ch_ofs;
  logic [7:0] du_sel;
  logic [7:0] ch_sel;
  logic       soft_reset;

  assign hit_ca = (addr_in == gcd_pkg::OFS_CONTROL_A);
  assign hit_du = (addr_in >= gcd_pkg::OFS_DIV_BASE) && (addr_in < DIV_END)
                  && (addr_in[1:0] == 2'h0);
  assign hit_ch = (addr_in >= gcd_pkg::OFS_CHAN_BASE) && (addr_in < CHAN_END)
                  && (addr_in[1:0] == 2'h0);
  assign du_ofs = addr_in - gcd_pkg::OFS_DIV_BASE;
  assign ch_ofs = addr_in - gcd_pkg::OFS_CHAN_BASE;
  assign du_sel = {2'h0, du_ofs[7:2]};
  assign ch_sel = {2'h0, ch_ofs[7:2]};
  // Control A has only the self-clearing soft reset bit; nothing stays stored
  assign soft_reset = wr_in && hit_ca && wdata_in[gcd_pkg::CA_SOFT_RESET_POS];

  function automatic logic ch_on(input logic [31:0] c);
    return c[gcd_pkg::CH_EN_POS];
  endfunction

  function automatic logic ch_locked(input logic [31:0] c);
    return c[gcd_pkg::CH_LOCK_POS];
  endfunction

  function automatic logic [gcd_pkg::IDX_W-1:0] ch_idx(input logic [31:0] c);
    return c[gcd_pkg::CH_IDX_POS +: gcd_pkg::IDX_W];
  endfunction

  // A unit survives soft reset when any locked channel names it
  always_comb begin
    du_keep = '0;
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (ch_locked(ch_ctl_r[c])) begin
        du_keep[ch_idx(ch_ctl_r[c])] = 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      assign ch_keep[g] = ch_locked(ch_ctl_r[g]);
      always_ff @(posedge clock_in) begin
        if (srst_in) begin
          ch_ctl_r[g] <= gcd_pkg::CH_RESET_VAL;
        end else if (soft_reset && !ch_keep[g]) begin
          ch_ctl_r[g] <= gcd_pkg::CH_RESET_VAL;
        end else if (wr_in && hit_ch && ch_sel == 8'(g) && !ch_keep[g]) begin
          // A locked channel ignores writes until hard reset
          ch_ctl_r[g] <= {24'h0, wdata_in[7:0]};
        end
      end
      // Channel gate: a stopped channel or a stopped unit gives no edges
      always_ff @(posedge clock_in) begin
        if (srst_in) begin
          ch_clk_r[g] <= 1'b0;
        end else begin
          ch_clk_r[g] <= ch_on(ch_ctl_r[g]) & du_clk[ch_idx(ch_ctl_r[g])];
        end
      end
    end

    for (g = 0; g < NUM_DIV; g++) begin : g_div
      gcd_div_if               dif ();
      logic [2:0]              src_sel;
      logic                    pad_oe;
      logic [gcd_pkg::NUM_SRC-1:0] src_vec;

      always_ff @(posedge clock_in) begin
        if (srst_in) begin
          du_ctl_r[g] <= gcd_pkg::DU_RESET_VAL;
        end else if (soft_reset && !du_keep[g]) begin
          du_ctl_r[g] <= gcd_pkg::DU_RESET_VAL;
        end else if (wr_in && hit_du && du_sel == 8'(g) && !du_keep[g]) begin
          du_ctl_r[g] <= {8'h0, wdata_in[23:0]};
        end
      end

      assign src_sel = du_ctl_r[g][gcd_pkg::DU_SRC_POS +: gcd_pkg::SRC_SEL_W];
      assign pad_oe  = du_ctl_r[g][gcd_pkg::DU_PAD_OE_POS];
      // Slot 0 is the unit's own pad when used as input; slot 7 is unit 1 output,
      // except on unit 1 itself where slot 7 reads low (seven choices)
      always_comb begin
        src_vec = src_clk_in;
        src_vec[0] = pad_oe ? 1'b0 : pad_in[g];
        src_vec[gcd_pkg::SRC_DIV1] = (g == 1) ? 1'b0 : du_clk[1 % NUM_DIV];
      end
      assign dif.on      = du_ctl_r[g][gcd_pkg::DU_ON_POS];
      assign dif.divide_select  = du_ctl_r[g][gcd_pkg::DU_DIVIDE_SELECT_POS];
      assign dif.factor  = du_ctl_r[g][gcd_pkg::DU_FACTOR_POS +: gcd_pkg::DIV_W];
      assign dif.src_clk = src_vec[src_sel];
      assign du_clk[g]   = dif.clk_out;

      gcd_divider u_div (
        .clock_in (clock_in),
        .srst_in  (srst_in),
        .du       (dif)
      );

      assign pad_out[g]    = dif.clk_out;
      assign pad_oe_out[g] = pad_oe;
    end
  endgenerate

  assign main_clock_feed_out  = du_clk[0];
  assign peripheral_clock_out = ch_clk_r;

  // Read port: data stand in the cycle after the strobe only
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < NUM_DIV; i++) begin
      if (hit_du && du_sel == 8'(i)) begin
        rd_mux = du_ctl_r[i];
      end
    end
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (hit_ch && ch_sel == 8'(i)) begin
        rd_mux = ch_ctl_r[i];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in || !rd_in) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rd_mux;
    end
  end

  assign rdata_out = rdata_r;
endmodule // gcd_top
`default_nettype wire

// file: tb/gcd_periph_model.sv
// Peripheral side model: counts rising edges of every delivered clock
`timescale 1ns/10ps
`default_nettype none
module gcd_periph_model #(parameter int N = 9) (
  input  wire logic               clock_in,
  input  wire logic               clr_in,
  input  wire logic [N-1:0]       clk_in,
  output logic      [N-1:0][7:0]  cnt_out
);
  logic [N-1:0] prev_r;
  always_ff @(posedge clock_in) begin
    prev_r <= clk_in;
    for (int i = 0; i < N; i++) begin
      if (clr_in) cnt_out[i] <= 8'h00;
      else if (clk_in[i] && !prev_r[i]) cnt_out[i] <= cnt_out[i] + 8'h01;
    end
  end
endmodule // gcd_periph_model
`default_nettype wire

// file: tb/gcd_top_sva.sv
// Checker of register port and clock outputs of the distribution unit
`timescale 1ns/10ps
`default_nettype none
module gcd_top_chk #(parameter int NUM_DIV = 4, parameter int NUM_CHAN = 8) (
  input wire logic                        clock_in,
  input wire logic                        srst_in,
  input wire logic [7:0]                  addr_in,
  input wire logic [31:0]                 wdata_in,
  input wire logic                        wr_in,
  input wire logic                        rd_in,
  input wire logic [31:0]                 rdata_out,
  input wire logic [7:0]                  src_clk_in,
  input wire logic [NUM_DIV-1:0]          pad_in,
  input wire logic [NUM_DIV-1:0]          pad_out,
  input wire logic [NUM_DIV-1:0]          pad_oe_out,
  input wire logic                        main_clock_feed_out,
  input wire logic [NUM_CHAN-1:0]         peripheral_clock_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // Units named by a lock may refuse writes, so those cases are skipped
  logic [3:0] lk_r;
  logic       cl0_r;
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      lk_r  <= 4'h0;
      cl0_r <= 1'b0;
    end else if (wr_in && addr_in[7] && wdata_in[7]) begin
      lk_r[wdata_in[1:0]] <= 1'b1;
      cl0_r               <= cl0_r | (addr_in == 8'h80);
    end
  end
  wire logic u0w = wr_in && addr_in == 8'h20;
  wire logic c0w = wr_in && addr_in == 8'h80;
  property p_rd_gap; !$past(rd_in) |-> rdata_out == 32'h0; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read data outside slot");
  property p_ctla; rd_in && addr_in == 8'h00 |=> rdata_out == 32'h0; endproperty
  a_ctla: assert property (p_ctla) else $error("control A reads nonzero");
  property p_misal; rd_in && addr_in[1:0] != 2'h0 |=> rdata_out == 32'h0; endproperty
  a_misal: assert property (p_misal) else $error("misaligned read nonzero");
  property p_rst;
    $past(srst_in) |-> {pad_out, pad_oe_out, main_clock_feed_out, peripheral_clock_out} == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_u0off; u0w && !wdata_in[8] && !lk_r[0] ##1 !u0w [*6] |-> !main_clock_feed_out;
  endproperty
  a_u0off: assert property (p_u0off) else $error("main feed runs while off");
  property p_oe3; wr_in && addr_in == 8'h2C && !lk_r[3] |=> pad_oe_out[3] == $past(wdata_in[11]);
  endproperty
  a_oe3: assert property (p_oe3) else $error("pad 3 enable wrong");
  property p_ch0off; c0w && !wdata_in[6] && !cl0_r ##1 !c0w [*6] |-> !peripheral_clock_out[0];
  endproperty
  a_ch0off: assert property (p_ch0off) else $error("channel 0 runs while off");
  property p_soft_reset_bit; wr_in && addr_in == 8'h00 && wdata_in[0] && lk_r == 4'h0 |=> pad_oe_out == '0;
  endproperty
  a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset kept pad enable");
  c_main: cover property ($rose(main_clock_feed_out));
  c_chan: cover property ($rose(peripheral_clock_out[1]));
  c_lock: cover property (wr_in && addr_in == 8'h00 && wdata_in[0] && lk_r != 4'h0);
endmodule // gcd_top_chk
bind gcd_top gcd_top_chk #(.NUM_DIV(NUM_DIV), .NUM_CHAN(NUM_CHAN)) gcd_top_chk_inst (
  .clock_in(clock_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .src_clk_in(src_clk_in),
  .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe_out),
  .main_clock_feed_out(main_clock_feed_out), .peripheral_clock_out(peripheral_clock_out));
`default_nettype wire

// file: tb/tb_gcd_top.sv
// Self-checking bench of the clock distribution unit
`timescale 1ns/10ps
`default_nettype none
module tb_gcd_top;
  logic            clock_in = 1'b0;
  logic            srst_in = 1'b1;
  logic [7:0]      addr_in = 8'h00;
  logic [31:0]     wdata_in = 32'h0;
  logic            wr_in = 1'b0;
  logic            rd_in = 1'b0;
  logic [7:0]      src_clk_in = 8'h00;
  logic [3:0]      pad_in = 4'h0;
  logic [31:0]     rdata_out;
  logic [3:0]      pad_out;
  logic [3:0]      pad_oe_out;
  logic            main_clock_feed_out;
  logic [7:0]      peripheral_clock_out;
  logic            clr = 1'b1;
  logic [12:0][7:0] cnt;
  int              error_cnt = 0;
  int              total_checks = 0;
  int              cyc = 0;
  gcd_top gcd_top_inst (.clock_in(clock_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .src_clk_in(src_clk_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe_out),
    .main_clock_feed_out(main_clock_feed_out), .peripheral_clock_out(peripheral_clock_out));
  // Pads sit above the main feed so every driven clock output gets an edge count
  gcd_periph_model #(.N(13)) gcd_periph_model_inst (.clock_in(clock_in), .clr_in(clr),
    .clk_in({pad_out, main_clock_feed_out, peripheral_clock_out}), .cnt_out(cnt));
  always #50 clock_in = ~clock_in;
  // Source 1 runs from time zero, ahead of any unit that selects it
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    src_clk_in <= src_clk_in ^ 8'h02;
    pad_in <= ~pad_in;
    if (cyc == 2000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Nonzero edge counts get one of slack: the window start is not phase aligned
  task automatic ce(string n, int e, int t, logic [7:0] g);
    total_checks++;
    if ((g >= e - t && g <= e + t) !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, string n);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1;
    chk(n, e, rdata_out);
    @(posedge clock_in);
  endtask
  task automatic win(int n);
    clr <= 1'b1;
    repeat (4) @(posedge clock_in);
    clr <= 1'b0;
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  initial begin
    repeat (10) @(posedge clock_in);
    srst_in <= 1'b0;
    @(posedge clock_in);
    rd(8'h00, 32'h0, "control_a");
    rd(8'h20, 32'h0, "unit0");
    rd(8'h84, 32'h0, "chan1");
    rd(8'h10, 32'h0, "unmapped");
    rd(8'h22, 32'h0, "misaligned");
    $display("test reset done");
    wr(8'h20, 32'h0000_0101);
    rd(8'h20, 32'h0000_0101, "unit0");
    win(40);
    ce("main pass", 20, 1, cnt[8]);
    ce("pad0 out", 20, 1, cnt[9]);
    wr(8'h20, 32'h0002_1101);
    win(40);
    ce("main div", 5, 1, cnt[8]);
    wr(8'h20, 32'h0);
    win(20);
    ce("main off", 0, 0, cnt[8]);
    $display("test unit0 done");
    wr(8'h24, 32'h0000_0101);
    wr(8'h28, 32'h0000_0107);
    wr(8'h2C, 32'h0000_0800);
    chk("pad_oe", 32'h8, {28'h0, pad_oe_out});
    wr(8'h84, 32'h41);
    wr(8'h88, 32'h41);
    wr(8'h8C, 32'h43);
    wr(8'h90, 32'h42);
    wr(8'h80, 32'h0);
    win(40);
    ce("chan1", 20, 1, cnt[1]);
    ce("chan2", 20, 1, cnt[2]);
    ce("chan3", 0, 0, cnt[3]);
    ce("chan4", 20, 1, cnt[4]);
    ce("chan0", 0, 0, cnt[0]);
    wr(8'h24, 32'h0000_0107);
    win(20);
    ce("chan1 slot7", 0, 0, cnt[1]);
    wr(8'h2C, 32'h0000_0100);
    win(40);
    ce("chan3 pad in", 20, 1, cnt[3]);
    ce("pad3 out", 20, 1, cnt[12]);
    wr(8'h2C, 32'h0000_0900);
    win(20);
    ce("chan3 pad driven", 0, 0, cnt[3]);
    $display("test channels done");
    wr(8'h00, 32'h1);
    rd(8'h24, 32'h0, "unit1");
    rd(8'h2C, 32'h0, "unit3");
    rd(8'h84, 32'h0, "chan1");
    wr(8'h24, 32'h0000_0101);
    wr(8'h84, 32'hC1);
    wr(8'h88, 32'h41);
    wr(8'h00, 32'h1);
    rd(8'h24, 32'h0000_0101, "unit1 locked");
    rd(8'h84, 32'hC1, "chan1 locked");
    rd(8'h88, 32'h0, "chan2");
    wr(8'h84, 32'h40);
    rd(8'h84, 32'hC1, "chan1 refused");
    win(40);
    ce("chan1 kept", 20, 1, cnt[1]);
    $display("test lock done");
    stop_test();
  end
endmodule // tb_gcd_top
`default_nettype wire
